// >>> mem_ctrl_pkg.sv
// Shared constants and types for the memory bus control-signal block.
// Assumes a single 125 MHz clock domain and a same-clock request source.
`default_nettype none

package mem_ctrl_pkg;

  // Data sizes in bits
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned HALF_BITS = 16;
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned DWORD_BITS = 64;
  localparam int unsigned LANES = WORD_BITS / BYTE_BITS;

  // Pin counts
  localparam int unsigned RAM_SELS = 10;
  localparam int unsigned IO_SELS = 4;
  localparam int unsigned STROBE_PAIR = 2;
  localparam int unsigned OE_PAIR = 2;
  localparam int unsigned WAIT_BITS = 4;

  // Slow-device hold-off limit in cycles before a timeout
  localparam int unsigned TIMEOUT_CYCLES = 256;

  typedef enum logic [2:0] {
    AREA_NONE = 3'h0,
    AREA_RAM = 3'h1,
    AREA_PROM = 3'h2,
    AREA_XCHG = 3'h3,
    AREA_IO = 3'h4,
    AREA_EXT = 3'h5
  } area_e;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2,
    SIZE_DWORD = 2'h3
  } size_e;

  // Gray-coded access sequence
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_WAIT = 2'h3,
    ST_DONE = 2'h2
  } acc_state_e;

endpackage

`default_nettype wire

// >>> mem_ctrl_helpers.sv
// Pin synchroniser and slow-device hold-off timer for the bus controller.
// Assumes one clock; pin inputs arrive asynchronously.
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] pin_i, // Asynchronous pins
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);
  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic stable;
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          meta <= RESET_VAL[i];
          stable <= RESET_VAL[i];
        end else begin
          meta <= pin_i[i];
          stable <= meta;
        end
      end
      assign sync_o[i] = stable;
    end
  endgenerate
endmodule // pin_sync

module holdoff_timer #(
  parameter int unsigned LIMIT = mem_ctrl_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic clear_i, // Start of a new access
  input wire logic run_i, // Access is being held off
  output logic expired_o // Held off beyond LIMIT cycles
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  initial begin
    if (LIMIT < 1) $error("holdoff_timer: LIMIT must be at least 1");
  end

  always_comb begin
    next_cnt = cnt;
    if (clear_i) begin
      next_cnt = '0;
    end else if (run_i && cnt != CW'(LIMIT)) begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // LIMIT cycles already spent, so this held cycle is the one too many
  assign expired_o = run_i && cnt == CW'(LIMIT);
endmodule // holdoff_timer

`default_nettype wire

// >>> mem_bus_ctrl.sv
// Memory and I/O bus control-signal generator: latch enable, buffer
// enables and direction, chip selects, write strobes and output enables.
// Assumes the requester decodes the area and supplies wait states.
`default_nettype none

module mem_bus_ctrl #(
  parameter int unsigned TIMEOUT_CYCLES = mem_ctrl_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk_i, // System clock, 125 MHz
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic req_i, // Access request, taken when idle_o
  input wire mem_ctrl_pkg::area_e area_i, // Decoded target area
  input wire logic write_i, // 1 write, 0 read
  input wire mem_ctrl_pkg::size_e size_i, // Access size
  input wire logic [1:0] addr_lo_i, // Byte address bits
  input wire logic [3:0] ram_bank_i, // RAM chip select index 0..9
  input wire logic [1:0] io_index_i, // I/O device index
  input wire logic [mem_ctrl_pkg::WAIT_BITS-1:0] wait_states_i, // Wait states
  input wire logic slow_dev_ready_n_i, // Slow device ready pin, low ready
  input wire logic slow_dev_error_n_i, // Slow device error pin, low error
  output logic idle_o, // Ready for a request
  output logic done_o, // Access finished, one cycle
  output logic bus_err_o, // Finished with device error, one cycle
  output logic timeout_o, // Finished by timeout, one cycle
  output logic [mem_ctrl_pkg::LANES-1:0] lane_en_o, // Byte lanes, [3]=D31:24
  output logic ale_n_o, // Address latch enable, low
  output logic ram_buf_en_n_o, // RAM buffer enable, low
  output logic prom_buf_en_n_o, // PROM buffer enable, low
  output logic common_mem_buf_en_n_o, // Common memory buffer enable, low
  output logic io_buf_en_n_o, // I/O buffer enable, low
  output logic data_buf_dir_o, // Buffer direction, 1 toward memory
  output logic data_buf_dir_n_o, // Complement of direction
  output logic [mem_ctrl_pkg::RAM_SELS-1:0] ram_sel_n_o, // RAM selects, low
  output logic prom_sel_n_o, // PROM select, low
  output logic [mem_ctrl_pkg::IO_SELS-1:0] io_dev_sel_o, // I/O selects, high
  output logic xchg_mem_sel_n_o, // Exchange memory select, low
  output logic [mem_ctrl_pkg::STROBE_PAIR-1:0] data_wr_strobe_n_o, // Data strobe
  output logic [mem_ctrl_pkg::STROBE_PAIR-1:0] check_wr_strobe_n_o, // Check strobe
  output logic io_wr_strobe_n_o, // I/O and exchange write strobe, low
  output logic [mem_ctrl_pkg::OE_PAIR-1:0] mem_oe_n_o // Memory output enable
);
  initial begin
    if (TIMEOUT_CYCLES < 1) $error("mem_bus_ctrl: TIMEOUT_CYCLES must be positive");
  end

  mem_ctrl_pkg::acc_state_e state, next_state;
  mem_ctrl_pkg::area_e area, next_area;
  mem_ctrl_pkg::size_e size, next_size;
  logic write, next_write;
  logic [1:0] addr_lo, next_addr_lo;
  logic [3:0] ram_bank, next_ram_bank;
  logic [1:0] io_index, next_io_index;
  logic [mem_ctrl_pkg::WAIT_BITS-1:0] wait_cnt, next_wait_cnt;
  logic fin_err, next_fin_err;
  logic fin_to, next_fin_to;

  logic rdy_n, err_n, slow, held, expired;

  pin_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i({slow_dev_error_n_i, slow_dev_ready_n_i}),
    .sync_o({err_n, rdy_n})
  );

  assign slow = area == mem_ctrl_pkg::AREA_IO || area == mem_ctrl_pkg::AREA_XCHG ||
                area == mem_ctrl_pkg::AREA_EXT;
  assign held = state == mem_ctrl_pkg::ST_WAIT && slow && rdy_n;

  holdoff_timer #(.LIMIT(TIMEOUT_CYCLES)) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(state == mem_ctrl_pkg::ST_ADDR),
    .run_i(held),
    .expired_o(expired)
  );

  // Access sequence
  always_comb begin
    next_state = state;
    next_area = area;
    next_size = size;
    next_write = write;
    next_addr_lo = addr_lo;
    next_ram_bank = ram_bank;
    next_io_index = io_index;
    next_wait_cnt = wait_cnt;
    next_fin_err = 1'b0;
    next_fin_to = 1'b0;
    case (state)
      mem_ctrl_pkg::ST_IDLE: begin
        if (req_i) begin
          next_state = mem_ctrl_pkg::ST_ADDR;
          next_area = area_i;
          next_size = size_i;
          next_write = write_i;
          next_addr_lo = addr_lo_i;
          next_ram_bank = ram_bank_i;
          next_io_index = io_index_i;
        end
      end
      mem_ctrl_pkg::ST_ADDR: begin
        next_state = mem_ctrl_pkg::ST_WAIT;
        next_wait_cnt = wait_states_i;
      end
      mem_ctrl_pkg::ST_WAIT: begin
        if (slow && !err_n) begin
          next_state = mem_ctrl_pkg::ST_DONE;
          next_fin_err = 1'b1;
        end else if (expired) begin
          next_state = mem_ctrl_pkg::ST_DONE;
          next_fin_to = 1'b1;
        end else if (wait_cnt != '0) begin
          next_wait_cnt = wait_cnt - mem_ctrl_pkg::WAIT_BITS'(1);
        end else if (!slow || !rdy_n) begin
          next_state = mem_ctrl_pkg::ST_DONE;
        end
      end
      mem_ctrl_pkg::ST_DONE: begin
        next_state = mem_ctrl_pkg::ST_IDLE;
      end
      default: begin
        next_state = mem_ctrl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= mem_ctrl_pkg::ST_IDLE;
      area <= mem_ctrl_pkg::AREA_NONE;
      size <= mem_ctrl_pkg::SIZE_WORD;
      write <= 1'b0;
      addr_lo <= 2'h0;
      ram_bank <= 4'h0;
      io_index <= 2'h0;
      wait_cnt <= '0;
      fin_err <= 1'b0;
      fin_to <= 1'b0;
    end else begin
      state <= next_state;
      area <= next_area;
      size <= next_size;
      write <= next_write;
      addr_lo <= next_addr_lo;
      ram_bank <= next_ram_bank;
      io_index <= next_io_index;
      wait_cnt <= next_wait_cnt;
      fin_err <= next_fin_err;
      fin_to <= next_fin_to;
    end
  end

  assign idle_o = state == mem_ctrl_pkg::ST_IDLE;
  assign done_o = state == mem_ctrl_pkg::ST_DONE;
  assign bus_err_o = fin_err;
  assign timeout_o = fin_to;

  // Pin values are computed from the next state so every pin is a flop
  logic active_nx, strobe_nx, mem_nx, slow_nx;
  logic [mem_ctrl_pkg::LANES-1:0] next_lane_en;
  logic next_ale_n, next_ram_buf_n, next_prom_buf_n, next_common_buf_n, next_io_buf_n;
  logic next_dir, next_prom_sel_n, next_xchg_sel_n, next_io_wr_n, next_oe;
  logic [mem_ctrl_pkg::RAM_SELS-1:0] next_ram_sel_n;
  logic [mem_ctrl_pkg::IO_SELS-1:0] next_io_sel;
  logic next_mem_wr;

  always_comb begin
    active_nx = next_state == mem_ctrl_pkg::ST_ADDR || next_state == mem_ctrl_pkg::ST_WAIT;
    // Strobes fall only in the wait phase, after selects have settled
    strobe_nx = next_state == mem_ctrl_pkg::ST_WAIT && next_write;
    mem_nx = next_area == mem_ctrl_pkg::AREA_RAM || next_area == mem_ctrl_pkg::AREA_PROM;
    slow_nx = next_area == mem_ctrl_pkg::AREA_IO || next_area == mem_ctrl_pkg::AREA_XCHG ||
              next_area == mem_ctrl_pkg::AREA_EXT;
    case (next_size)
      mem_ctrl_pkg::SIZE_BYTE: next_lane_en = 4'h8 >> next_addr_lo;
      mem_ctrl_pkg::SIZE_HALF: next_lane_en = next_addr_lo[1] ? 4'h3 : 4'hc;
      default: next_lane_en = 4'hf;
    endcase
    next_ale_n = !(next_state == mem_ctrl_pkg::ST_ADDR);
    next_ram_buf_n = !(active_nx && next_area == mem_ctrl_pkg::AREA_RAM);
    next_prom_buf_n = !(active_nx && next_area == mem_ctrl_pkg::AREA_PROM);
    next_common_buf_n = !(active_nx && mem_nx);
    next_io_buf_n = !(active_nx && slow_nx);
    next_dir = active_nx && next_write;
    next_ram_sel_n = '1;
    if (active_nx && next_area == mem_ctrl_pkg::AREA_RAM &&
        next_ram_bank < 4'(mem_ctrl_pkg::RAM_SELS)) begin
      next_ram_sel_n[next_ram_bank] = 1'b0;
    end
    next_prom_sel_n = !(active_nx && next_area == mem_ctrl_pkg::AREA_PROM);
    next_xchg_sel_n = !(active_nx && next_area == mem_ctrl_pkg::AREA_XCHG);
    next_io_sel = '0;
    if (active_nx && next_area == mem_ctrl_pkg::AREA_IO) begin
      next_io_sel[next_io_index] = 1'b1;
    end
    next_mem_wr = strobe_nx && mem_nx;
    next_io_wr_n = !(strobe_nx && (next_area == mem_ctrl_pkg::AREA_IO ||
                                   next_area == mem_ctrl_pkg::AREA_XCHG));
    next_oe = next_state == mem_ctrl_pkg::ST_WAIT && !next_write && mem_nx;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lane_en_o <= '0;
      ale_n_o <= 1'b1;
      ram_buf_en_n_o <= 1'b1;
      prom_buf_en_n_o <= 1'b1;
      common_mem_buf_en_n_o <= 1'b1;
      io_buf_en_n_o <= 1'b1;
      data_buf_dir_o <= 1'b0;
      data_buf_dir_n_o <= 1'b1;
      ram_sel_n_o <= '1;
      prom_sel_n_o <= 1'b1;
      io_dev_sel_o <= '0;
      xchg_mem_sel_n_o <= 1'b1;
      data_wr_strobe_n_o <= '1;
      check_wr_strobe_n_o <= '1;
      io_wr_strobe_n_o <= 1'b1;
      mem_oe_n_o <= '1;
    end else begin
      lane_en_o <= active_nx ? next_lane_en : 4'h0;
      ale_n_o <= next_ale_n;
      ram_buf_en_n_o <= next_ram_buf_n;
      prom_buf_en_n_o <= next_prom_buf_n;
      common_mem_buf_en_n_o <= next_common_buf_n;
      io_buf_en_n_o <= next_io_buf_n;
      data_buf_dir_o <= next_dir;
      data_buf_dir_n_o <= !next_dir;
      ram_sel_n_o <= next_ram_sel_n;
      prom_sel_n_o <= next_prom_sel_n;
      io_dev_sel_o <= next_io_sel;
      xchg_mem_sel_n_o <= next_xchg_sel_n;
      data_wr_strobe_n_o <= {mem_ctrl_pkg::STROBE_PAIR{!next_mem_wr}};
      check_wr_strobe_n_o <= {mem_ctrl_pkg::STROBE_PAIR{!next_mem_wr}};
      io_wr_strobe_n_o <= next_io_wr_n;
      mem_oe_n_o <= {mem_ctrl_pkg::OE_PAIR{!next_oe}};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_take;
    idle_o && req_i;
  endsequence
  sequence s_latch;
    !ale_n_o ##1 ale_n_o;
  endsequence

  AST_ALE_ON_TAKE: assert property (s_take |=> s_latch)
    else $error("Latch enable did not pulse after request");
  AST_ALE_ONCE: assert property (!ale_n_o |=> ale_n_o until_with done_o)
    else $error("Latch enable pulsed twice in one access");
  AST_RAM_BUF: assert property (ram_sel_n_o != '1 |->
                                !ram_buf_en_n_o && !common_mem_buf_en_n_o)
    else $error("RAM buffer not enabled with RAM select");
  AST_PROM_BUF: assert property (!prom_sel_n_o |-> !prom_buf_en_n_o && !common_mem_buf_en_n_o)
    else $error("PROM buffers not enabled with PROM select");
  AST_IO_BUF: assert property (!xchg_mem_sel_n_o || io_dev_sel_o != '0 |-> !io_buf_en_n_o)
    else $error("I/O buffer not enabled for slow access");
  AST_DIR_PAIR: assert property (data_buf_dir_o != data_buf_dir_n_o)
    else $error("Direction pair not complementary");
  AST_ONE_SEL: assert property ($countones({~ram_sel_n_o, ~prom_sel_n_o, io_dev_sel_o,
                                            ~xchg_mem_sel_n_o}) <= 1)
    else $error("More than one area select active");
  AST_STROBE_SPLIT: assert property (!io_wr_strobe_n_o |-> data_wr_strobe_n_o == 2'h3 &&
                                     check_wr_strobe_n_o == 2'h3)
    else $error("Memory strobe active during I/O write");
  AST_WR_DIR: assert property (data_wr_strobe_n_o != 2'h3 |-> data_buf_dir_o &&
                               mem_oe_n_o == 2'h3)
    else $error("Memory write without write direction");
  AST_ERR_END: assert property (state == mem_ctrl_pkg::ST_WAIT && slow && !err_n
                                |=> done_o && bus_err_o)
    else $error("Device error did not end access");
  AST_HOLD_END: assert property (held && wait_cnt == '0 ##1 state == mem_ctrl_pkg::ST_WAIT
                                 && !rdy_n && err_n && !expired |=> done_o)
    else $error("Ready did not end held access");
  AST_TIMEOUT: assert property ($rose(timeout_o) |-> $past(held) && done_o)
    else $error("Timeout without hold-off");
endmodule // mem_bus_ctrl

`default_nettype wire

// >>> slow_dev_model.sv
// Behavioural slow device on the ready and error pins of the bus controller.
// Assumes the bench sets the reply delay and the error command per access.
`default_nettype none

module slow_dev_model (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic io_buf_en_n_i, // Slow-area buffer enable, low
  input wire logic common_mem_buf_en_n_i, // Memory buffer enable, low
  input wire logic [7:0] ready_delay_i, // Cycles before ready, ff never
  input wire logic err_cmd_i, // Answer with an error
  output logic slow_dev_ready_n_o, // Ready pin, low ready
  output logic slow_dev_error_n_o // Error pin, low error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic active;
  logic due;

  // Pins are pulled up, so an unselected device leaves both high
  assign active = !io_buf_en_n_i || !common_mem_buf_en_n_i;
  assign due = active && (cnt >= ready_delay_i) && (ready_delay_i != 8'hff);

  always_ff @(posedge clk_i) begin
    if (reset_i || !active) begin
      cnt <= 8'h0;
    end else if (cnt != 8'hfe) begin
      cnt <= cnt + 8'h1;
    end
    slow_dev_ready_n_o <= !(due && !reset_i);
    slow_dev_error_n_o <= !(err_cmd_i && active && (cnt >= ready_delay_i) && !reset_i);
  end
endmodule // slow_dev_model

`default_nettype wire

// >>> mem_bus_ctrl_test.sv
// Self-checking bench for the memory bus control-signal generator.
// Assumes slow_dev_model answers on the ready and error pins.
`default_nettype none
`define chk(g, e, m) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t %s", $time, m); end end

module mem_bus_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 8;
  typedef struct {
    logic [3:0] lanes; logic [3:0] buf_n; logic dir; logic [9:0] ram_sel_n;
    logic [3:0] io_sel; logic [1:0] other_sel_n; logic [3:0] strb;
    logic err; logic tmo; int lat_lo; int lat_hi;
  } expect_s;
  logic clk_i, reset_i, req_i, write_i, ready_n, error_n, err_cmd;
  mem_ctrl_pkg::area_e area_i;
  mem_ctrl_pkg::size_e size_i;
  logic [1:0] addr_lo_i, io_index_i, data_wr, check_wr, mem_oe;
  logic [3:0] ram_bank_i, wait_states_i, lanes, io_sel, seen;
  logic [7:0] ready_delay;
  logic idle_o, done_o, bus_err_o, timeout_o, ale_n, ram_be, prom_be, com_be, io_be;
  logic dir, dir_n, prom_sel_n, xchg_sel_n, io_wr_n, strb_in_ale;
  logic [9:0] ram_sel_n;
  expect_s exp_q[$];
  expect_s cap;
  expect_s e;
  int failures, checks, ale_cnt, lat;

  mem_bus_ctrl #(.TIMEOUT_CYCLES(TMO)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .area_i(area_i), .write_i(write_i),
    .size_i(size_i), .addr_lo_i(addr_lo_i), .ram_bank_i(ram_bank_i),
    .io_index_i(io_index_i), .wait_states_i(wait_states_i),
    .slow_dev_ready_n_i(ready_n), .slow_dev_error_n_i(error_n), .idle_o(idle_o),
    .done_o(done_o), .bus_err_o(bus_err_o), .timeout_o(timeout_o), .lane_en_o(lanes),
    .ale_n_o(ale_n), .ram_buf_en_n_o(ram_be), .prom_buf_en_n_o(prom_be),
    .common_mem_buf_en_n_o(com_be), .io_buf_en_n_o(io_be), .data_buf_dir_o(dir),
    .data_buf_dir_n_o(dir_n), .ram_sel_n_o(ram_sel_n), .prom_sel_n_o(prom_sel_n),
    .io_dev_sel_o(io_sel), .xchg_mem_sel_n_o(xchg_sel_n), .data_wr_strobe_n_o(data_wr),
    .check_wr_strobe_n_o(check_wr), .io_wr_strobe_n_o(io_wr_n), .mem_oe_n_o(mem_oe)
  );

  slow_dev_model u_dev (
    .clk_i(clk_i), .reset_i(reset_i), .io_buf_en_n_i(io_be), .common_mem_buf_en_n_i(com_be),
    .ready_delay_i(ready_delay), .err_cmd_i(err_cmd), .slow_dev_ready_n_o(ready_n),
    .slow_dev_error_n_o(error_n)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [3:0] lanes_of(mem_ctrl_pkg::size_e s, logic [1:0] a);
    case (s)
      mem_ctrl_pkg::SIZE_BYTE: return 4'h8 >> a;
      mem_ctrl_pkg::SIZE_HALF: return a[1] ? 4'h3 : 4'hc;
      default: return 4'hf;
    endcase
  endfunction

  task automatic access(input int ai, input logic w, input int waits, input logic [7:0] dly,
                        input logic err);
    expect_s x;
    mem_ctrl_pkg::area_e a;
    mem_ctrl_pkg::size_e sz;
    logic [1:0] ad, io;
    logic [3:0] bk;
    logic mem, slow;
    int n;
    a = mem_ctrl_pkg::area_e'(ai[2:0]);
    sz = mem_ctrl_pkg::size_e'($urandom_range(3));
    ad = 2'($urandom_range(3));
    io = 2'($urandom_range(3));
    bk = 4'($urandom_range(15));
    mem = (a == mem_ctrl_pkg::AREA_RAM) || (a == mem_ctrl_pkg::AREA_PROM);
    slow = (a == mem_ctrl_pkg::AREA_XCHG) || (a == mem_ctrl_pkg::AREA_IO) ||
           (a == mem_ctrl_pkg::AREA_EXT);
    x.lanes = lanes_of(sz, ad);
    x.buf_n = {a != mem_ctrl_pkg::AREA_RAM, a != mem_ctrl_pkg::AREA_PROM, !mem, !slow};
    x.dir = w;
    x.ram_sel_n = (a == mem_ctrl_pkg::AREA_RAM) ? ~(10'h1 << bk) : 10'h3ff;
    x.io_sel = (a == mem_ctrl_pkg::AREA_IO) ? 4'h1 << io : 4'h0;
    x.other_sel_n = {a != mem_ctrl_pkg::AREA_PROM, a != mem_ctrl_pkg::AREA_XCHG};
    x.strb = {mem & w, mem & w,
              w & (a == mem_ctrl_pkg::AREA_IO || a == mem_ctrl_pkg::AREA_XCHG), mem & !w};
    x.err = slow & err;
    x.tmo = slow & !err & (dly == 8'hff);
    x.lat_lo = x.tmo ? TMO + 1 : (slow ? 2 : 2 + waits);
    x.lat_hi = slow ? TMO + waits + 8 : 2 + waits;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (idle_o !== 1'b1 && n < 300);
    @(posedge clk_i);
    req_i <= 1'b1;
    area_i <= a;
    write_i <= w;
    size_i <= sz;
    addr_lo_i <= ad;
    ram_bank_i <= bk;
    io_index_i <= io;
    wait_states_i <= 4'(waits);
    ready_delay <= dly;
    err_cmd <= err;
    exp_q.push_back(x);
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 300);
    if (n >= 300) begin
      failures++;
      $display("[FAIL] %0t access never finished", $time);
    end
  endtask

  // Watches the pins of each access and compares at its end
  always @(negedge clk_i) begin
    if (!reset_i) begin
      `chk(dir_n, ~dir, "direction pair not complementary")
      `chk($countones({~ram_sel_n, ~prom_sel_n, ~xchg_sel_n, io_sel}) <= 1, 1'b1, "selects")
      if (ale_n === 1'b0) begin
        ale_cnt++;
        lat = 0;
        cap.lanes = lanes;
        cap.buf_n = {ram_be, prom_be, com_be, io_be};
        cap.dir = dir;
        cap.ram_sel_n = ram_sel_n;
        cap.io_sel = io_sel;
        cap.other_sel_n = {prom_sel_n, xchg_sel_n};
        strb_in_ale = strb_in_ale | (data_wr != 2'h3) | (mem_oe != 2'h3);
      end else if (ale_cnt > 0) begin
        lat++;
        seen = seen | {data_wr == 2'h0, check_wr == 2'h0, !io_wr_n, mem_oe == 2'h0};
      end
      if (done_o === 1'b1) begin
        if (exp_q.size() == 0) begin
          failures++;
          $display("[FAIL] %0t unexpected completion", $time);
        end else begin
          e = exp_q.pop_front();
          `chk(ale_cnt, 1, "latch enable count")
          `chk(cap.lanes, e.lanes, "byte lanes")
          `chk(cap.buf_n, e.buf_n, "buffer enables")
          `chk(cap.dir, e.dir, "buffer direction")
          `chk(cap.ram_sel_n, e.ram_sel_n, "ram selects")
          `chk(cap.io_sel, e.io_sel, "io selects")
          `chk(cap.other_sel_n, e.other_sel_n, "prom or exchange select")
          `chk(seen, e.strb, "strobes or output enable")
          `chk(strb_in_ale, 1'b0, "strobe during address phase")
          `chk(bus_err_o, e.err, "device error flag")
          `chk(timeout_o, e.tmo, "timeout flag")
          `chk(lat >= e.lat_lo && lat <= e.lat_hi, 1'b1, "access length")
        end
        ale_cnt = 0;
        seen = 4'h0;
        strb_in_ale = 1'b0;
      end
    end
  end

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    {reset_i, req_i, write_i, err_cmd} = 4'h8;
    {addr_lo_i, io_index_i, ram_bank_i, wait_states_i, ready_delay} = '0;
    area_i = mem_ctrl_pkg::AREA_NONE;
    size_i = mem_ctrl_pkg::SIZE_WORD;
    {ale_cnt, lat, failures, checks} = '0;
    seen = 4'h0;
    strb_in_ale = 1'b0;
    void'($urandom(32'h070332df));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    `chk({idle_o, ale_n, io_sel, dir, done_o}, 8'hc0, "values after reset")
    for (int a = 0; a <= 5; a++) begin
      for (int w = 0; w < 2; w++) begin
        repeat (3) access(a, w[0], $urandom_range(3), 8'h0, 1'b0);
      end
    end
    $display("Test area decode done");
    for (int a = 3; a <= 5; a++) access(a, 1'($urandom_range(1)), 1, 8'h4, 1'b0);
    $display("Test slow ready done");
    for (int a = 1; a <= 5; a++) access(a, 1'($urandom_range(1)), 0, 8'h0, 1'b1);
    $display("Test device error done");
    for (int a = 3; a <= 5; a++) access(a, 1'($urandom_range(1)), 0, 8'hff, 1'b0);
    $display("Test timeout done");
    repeat (4) @(negedge clk_i);
    `chk(exp_q.size(), 0, "accesses left unfinished")
    give_verdict();
  end
endmodule // mem_bus_ctrl_test

`default_nettype wire
